// ### src/ced_dispatch.sv
// Exception and interrupt dispatch with an APB register slave.
// Assumes the core holds excReq until busy rises and answers vector reads.
// Operation
// RULE_01: Raise request only above current priority level
// RULE_02: Take interrupts at instruction end or points
// RULE_03: Pick highest source, set level, push, branch
// RULE_04: Frame is status pair plus exception parameters
// RULE_05: Halt input requests level 1F, unmaskable
// RULE_06: Hard error requests level 1D
// RULE_07: Performance event level 1B, serviced internally
// RULE_08: Soft error requests level 1A
// RULE_09: Lines 3..0 map 17..14; line 2 beats timer
// RULE_10: Only 23 levels; 01-0F are software
// RULE_11: Priority write loads status word bits 20:16
// RULE_12: Trap stacks next instruction address
// RULE_13: Fault stacks faulting instruction address
// RULE_14: Arithmetic via vector 34 with type code
// RULE_15: Memory faults share frame; vectors 20,24,3C
// RULE_16: Emulation frame holds opcode, specifiers, PCs, status
// RULE_17: First-part-done set gives fault via CC
// RULE_18: Machine check via vector 04 with state
// RULE_19: Bad state, kernel halt, restart go console
// RULE_20: Restart saves stack pointer, PC and status
// RULE_21: Handler address forces low two bits zero
// RULE_22: Entry low bits choose stack or halt
`timescale 1ns/1ns
module ced_dispatch
  import ced_pkg::*;
#(
  parameter int NUM_IRQ = 4,
  parameter int SPEC_COUNT = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltReq,
  input wire logic hardErrIn,
  input wire logic hardErrEvt,
  input wire logic softErrEvt,
  input wire logic perfEvt,
  input wire logic [NUM_IRQ-1:0] irqLines,
  input wire logic timerReq,
  input wire logic instrDone,
  input wire logic interruptPoint,
  input wire logic [31:0] curPc,
  input wire logic [31:0] nextPc,
  input wire logic [31:0] curSp,
  input wire logic excReq,
  input wire ced_pkg::ced_exc_t excKind,
  input wire logic [3:0] excArithCode,
  input wire logic [31:0] excParam,
  input wire logic [31:0] excVaddr,
  input wire logic [7:0] emuOpcode,
  input wire logic [SPEC_COUNT*32-1:0] emuSpecs,
  input wire logic [7:0] mcErrType,
  input wire logic [31:0] mcState,
  input wire logic stateBad,
  input wire logic kernelHalt,
  input wire logic sysRestart,
  input wire logic vecAck,
  input wire logic [31:0] vecData,
  output logic busy,
  output logic vecRd,
  output logic [31:0] vecAddr,
  output logic pushValid,
  output logic [31:0] pushData,
  output logic pushOnIntStack,
  output logic branchValid,
  output logic [31:0] branchPc,
  output logic perfService,
  output logic consoleJump,
  output logic [31:0] consoleAddr,
  output logic [31:0] statusWord
);
  import ced_pkg::*;

  initial begin
    if (SPEC_COUNT != 8) $error("ced_dispatch frame layout needs eight specifiers");
  end

  ced_state_t state_q;
  logic [31:0] psw_q, vecBase_q, consoleEntry_q, savedPc_q, savedSw_q;
  logic [31:0] spSave_q [SP_SAVE_COUNT];
  logic [15:1] softPend_q;
  logic hardPend_q, perfPend_q, softErrPend_q, intReq_q;
  logic [31:0] frame_q [FRAME_MAX];
  logic [3:0] frameLen_q, pushIdx_q;
  logic isExc_q;
  logic [15:0] vecOfs_q;
  logic [4:0] takenLevel_q;
  logic [5:0] haltCode_q;
  logic [31:0] prdata_q, vecAddr_q, pushData_q, branchPc_q, consoleAddr_q;
  logic pready_q, pslverr_q, vecRd_q, pushValid_q, pushIntStk_q, branchValid_q;
  logic perfService_q, consoleJump_q;
  logic [4:0] bestLevel;
  logic [15:0] bestVec;
  logic [31:0] handlerPc;
  logic useIntStack, raiseToTop, consoleErr;
  logic apbAccess, apbWr, takeInt, restartReq;
  logic [2:0] spIdx;

  ced_int_arbiter #(
    .NUM_IRQ(NUM_IRQ)
  ) uArb (
    .haltReq(haltReq),
    .hardPend(hardPend_q),
    .perfPend(perfPend_q),
    .softErrPend(softErrPend_q),
    .irqLines(irqLines),
    .timerReq(timerReq),
    .softPend(softPend_q),
    .bestLevel(bestLevel),
    .bestVec(bestVec)
  );

  ced_vec_entry uVec (
    .entry(vecData),
    .onIntStack(psw_q[SW_ON_INT_STACK]),
    .isException(isExc_q),
    .handlerPc(handlerPc),
    .useIntStack(useIntStack),
    .raiseToTop(raiseToTop),
    .consoleErr(consoleErr)
  );

  assign apbAccess = psel && penable && !pready_q;
  assign apbWr = apbAccess && pwrite;
  assign restartReq = stateBad || kernelHalt || sysRestart;
  assign takeInt = intReq_q && (instrDone || interruptPoint); // see RULE_02
  assign spIdx = psw_q[SW_ON_INT_STACK] ? 3'd4 : {1'b0, psw_q[SW_MODE_LO+1:SW_MODE_LO]};

  // Registered so the request reflects halt or levels above the current one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intReq_q <= 1'b0;
    end else begin
      intReq_q <= haltReq || (bestLevel > psw_q[SW_IPL_HI:SW_IPL_LO]); // see RULE_01 RULE_05
    end
  end

  // Sticky pending sources; a new event wins over the clear on take
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hardPend_q <= 1'b0;
      perfPend_q <= 1'b0;
      softErrPend_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && takeInt && !excReq && !restartReq) begin
        if (bestLevel == LVL_HARD_ERR) hardPend_q <= 1'b0;
        if (bestLevel == LVL_PERF) perfPend_q <= 1'b0;
        if (bestLevel == LVL_SOFT_ERR) softErrPend_q <= 1'b0;
      end
      if (hardErrIn || hardErrEvt) hardPend_q <= 1'b1; // see RULE_06
      if (perfEvt) perfPend_q <= 1'b1; // see RULE_07
      if (softErrEvt) softErrPend_q <= 1'b1; // see RULE_08
    end
  end

  // Software request bits: set by register writes, cleared when serviced
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      softPend_q <= '0;
    end else begin
      if (state_q == ST_IDLE && takeInt && !excReq && !restartReq
          && bestLevel < LVL_IRQ0 && bestLevel != LVL_NONE) begin
        softPend_q[bestLevel[3:0]] <= 1'b0; // see RULE_10
      end
      if (state_q == ST_RESTART) begin
        softPend_q <= '0;
      end
      if (apbWr && paddr == OFS_SOFT_SUM) begin
        softPend_q <= pwdata[15:1];
      end
      if (apbWr && paddr == OFS_SOFT_REQ && pwdata[3:0] != 4'h0) begin
        softPend_q[pwdata[3:0]] <= 1'b1;
      end
    end
  end

  // Status word: dispatch updates win over a same-cycle register write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      psw_q <= SW_RESET;
    end else begin
      if (apbWr && paddr == OFS_STATUS) begin
        psw_q <= pwdata;
      end
      if (apbWr && paddr == OFS_PRIORITY) begin
        psw_q[SW_IPL_HI:SW_IPL_LO] <= pwdata[4:0]; // see RULE_11
      end
      if (state_q == ST_IDLE && !restartReq && !excReq && takeInt
          && bestLevel != LVL_HALT && bestLevel != LVL_PERF) begin
        psw_q[SW_IPL_HI:SW_IPL_LO] <= bestLevel; // see RULE_03
      end
      if (state_q == ST_FETCH && vecAck && !consoleErr) begin
        psw_q[SW_ON_INT_STACK] <= useIntStack; // see RULE_22
        if (raiseToTop) psw_q[SW_IPL_HI:SW_IPL_LO] <= LVL_HALT;
      end
      if (state_q == ST_RESTART) begin
        // Partial initialisation before the console takes over
        psw_q <= SW_RESET; // see RULE_19
      end
    end
  end

  // Frame contents, word 0 pushed first; parameters land above the pair
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frameLen_q <= 4'd0;
      isExc_q <= 1'b0;
      vecOfs_q <= 16'h0000;
      takenLevel_q <= LVL_NONE;
      for (int i = 0; i < FRAME_MAX; i++) frame_q[i] <= '0;
    end else if (state_q == ST_IDLE && !restartReq) begin
      frame_q[0] <= psw_q; // see RULE_04
      if (excReq) begin
        isExc_q <= 1'b1;
        unique case (excKind)
          EXC_ARITH: begin
            vecOfs_q <= VEC_ARITH; // see RULE_14
            if (excArithCode == AR_FLT_OVF || excArithCode == AR_FLT_DVZ
                || excArithCode == AR_FLT_UNF) begin
              frame_q[1] <= curPc; // see RULE_13
            end else begin
              frame_q[1] <= nextPc; // see RULE_12
            end
            frame_q[2] <= {28'h0, excArithCode}; // see RULE_14
            frameLen_q <= 4'd3;
          end
          EXC_ACCV, EXC_TNV, EXC_MODIFY: begin
            vecOfs_q <= (excKind == EXC_ACCV) ? VEC_ACCV :
                        (excKind == EXC_TNV) ? VEC_TNV : VEC_MODIFY; // see RULE_15
            frame_q[1] <= curPc; // see RULE_13 RULE_15
            frame_q[2] <= excVaddr;
            frame_q[3] <= excParam;
            frameLen_q <= 4'd4;
          end
          EXC_EMULATE: begin
            if (psw_q[SW_FPD]) begin
              vecOfs_q <= VEC_EMU_CONT; // see RULE_17
              frame_q[1] <= curPc;
              frameLen_q <= 4'd2;
            end else begin
              vecOfs_q <= VEC_EMU_START; // see RULE_16
              frame_q[1] <= nextPc;
              for (int s = 0; s < SPEC_COUNT; s++) begin
                frame_q[2+s] <= emuSpecs[(SPEC_COUNT-1-s)*32 +: 32];
              end
              frame_q[EMU_FRAME_LEN-2] <= curPc;
              frame_q[EMU_FRAME_LEN-1] <= {24'h0, emuOpcode};
              frameLen_q <= 4'(EMU_FRAME_LEN);
            end
          end
          EXC_MCHECK: begin
            vecOfs_q <= VEC_MCHECK; // see RULE_18
            frame_q[1] <= curPc;
            frame_q[2] <= mcState;
            frame_q[3] <= {24'h0, mcErrType};
            frameLen_q <= 4'd4;
          end
          default: begin
            vecOfs_q <= VEC_MCHECK;
            frame_q[1] <= curPc;
            frame_q[2] <= mcState;
            frame_q[3] <= 32'h0000_0000;
            frameLen_q <= 4'd4;
          end
        endcase
      end else if (takeInt) begin
        isExc_q <= 1'b0;
        vecOfs_q <= bestVec; // see RULE_03
        takenLevel_q <= bestLevel;
        frame_q[1] <= instrDone ? nextPc : curPc;
        frameLen_q <= 4'd2; // see RULE_04
      end
    end
  end

  // Dispatch sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      pushIdx_q <= 4'd0;
      haltCode_q <= 6'h00;
      vecRd_q <= 1'b0;
      vecAddr_q <= '0;
      pushValid_q <= 1'b0;
      pushData_q <= '0;
      pushIntStk_q <= 1'b0;
      branchValid_q <= 1'b0;
      branchPc_q <= '0;
      perfService_q <= 1'b0;
      consoleJump_q <= 1'b0;
      consoleAddr_q <= '0;
    end else begin
      pushValid_q <= 1'b0;
      branchValid_q <= 1'b0;
      perfService_q <= 1'b0;
      consoleJump_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          pushIdx_q <= 4'd0;
          if (restartReq) begin
            haltCode_q <= stateBad ? HALT_STATE_BAD :
                          kernelHalt ? HALT_KERNEL : HALT_SYS_RESTART; // see RULE_19
            state_q <= ST_RESTART;
          end else if (excReq) begin
            state_q <= ST_FETCH;
            vecRd_q <= 1'b1;
          end else if (takeInt) begin
            if (bestLevel == LVL_HALT) begin
              haltCode_q <= HALT_EXTERNAL; // see RULE_05
              state_q <= ST_RESTART;
            end else if (bestLevel == LVL_PERF) begin
              perfService_q <= 1'b1; // see RULE_07
            end else begin
              state_q <= ST_FETCH;
              vecRd_q <= 1'b1;
            end
          end
        end
        ST_FETCH: begin
          vecAddr_q <= vecBase_q + {16'h0, vecOfs_q};
          if (vecAck && vecRd_q) begin
            vecRd_q <= 1'b0;
            branchPc_q <= handlerPc; // see RULE_21
            pushIntStk_q <= useIntStack;
            if (consoleErr) begin
              haltCode_q <= HALT_VEC_CODE; // see RULE_22
              state_q <= ST_RESTART;
            end else begin
              state_q <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          pushValid_q <= 1'b1; // see RULE_03 RULE_04
          pushData_q <= frame_q[pushIdx_q];
          pushIdx_q <= pushIdx_q + 4'd1;
          if (pushIdx_q + 4'd1 == frameLen_q) state_q <= ST_BRANCH;
        end
        ST_BRANCH: begin
          branchValid_q <= 1'b1; // see RULE_03
          state_q <= ST_IDLE;
        end
        ST_RESTART: begin
          consoleJump_q <= 1'b1; // see RULE_19
          consoleAddr_q <= consoleEntry_q;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Vector address becomes valid the cycle after vecRd rises
  // Restart save area
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      savedPc_q <= '0;
      savedSw_q <= '0;
      for (int k = 0; k < SP_SAVE_COUNT; k++) spSave_q[k] <= '0;
    end else if (state_q == ST_RESTART) begin
      spSave_q[spIdx] <= curSp; // see RULE_20
      savedPc_q <= curPc;
      savedSw_q <= {psw_q[31:16], 1'b1, 1'b0, haltCode_q, psw_q[7:0]}; // see RULE_20
    end
  end

  // Software-set configuration
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vecBase_q <= '0;
      consoleEntry_q <= '0;
    end else begin
      if (apbWr && paddr == OFS_VEC_BASE) vecBase_q <= {pwdata[31:2], 2'b00};
      if (apbWr && paddr == OFS_CONSOLE) consoleEntry_q <= pwdata;
    end
  end

  // APB answer: one wait state, error on unmapped offsets
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apbAccess;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (apbAccess) begin
        unique case (paddr)
          OFS_PRIORITY: prdata_q <= {27'h0, psw_q[SW_IPL_HI:SW_IPL_LO]};
          OFS_SOFT_REQ: prdata_q <= '0;
          OFS_SOFT_SUM: prdata_q <= {16'h0, softPend_q, 1'b0};
          OFS_STATUS: prdata_q <= psw_q;
          OFS_VEC_BASE: prdata_q <= vecBase_q;
          OFS_CONSOLE: prdata_q <= consoleEntry_q;
          OFS_SAVED_PC: prdata_q <= savedPc_q;
          OFS_SAVED_SW: prdata_q <= savedSw_q;
          OFS_DISPATCH: prdata_q <= {16'h0, intReq_q, takenLevel_q, 7'h0, state_q};
          default: begin
            if (paddr >= OFS_SP_SAVE0 && paddr < OFS_DISPATCH && paddr[1:0] == 2'b00) begin
              prdata_q <= spSave_q[3'(paddr[4:2] - 3'd0)];
            end else begin
              pslverr_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = (state_q != ST_IDLE);
  assign vecRd = vecRd_q;
  assign vecAddr = vecAddr_q;
  assign pushValid = pushValid_q;
  assign pushData = pushData_q;
  assign pushOnIntStack = pushIntStk_q;
  assign branchValid = branchValid_q;
  assign branchPc = branchPc_q;
  assign perfService = perfService_q;
  assign consoleJump = consoleJump_q;
  assign consoleAddr = consoleAddr_q;
  assign statusWord = psw_q;
endmodule // ced_dispatch

// ### pkg/ced_pkg.sv
// Constants, field layouts and state encodings of the event dispatch block.
// Assumes a 32-bit status word and a vector table read one longword at a time.
package ced_pkg;
  // Register byte offsets on the APB side
  localparam logic [11:0] OFS_PRIORITY = 12'h000;
  localparam logic [11:0] OFS_SOFT_REQ = 12'h004;
  localparam logic [11:0] OFS_SOFT_SUM = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_VEC_BASE = 12'h010;
  localparam logic [11:0] OFS_CONSOLE = 12'h014;
  localparam logic [11:0] OFS_SAVED_PC = 12'h018;
  localparam logic [11:0] OFS_SAVED_SW = 12'h01c;
  localparam logic [11:0] OFS_SP_SAVE0 = 12'h020;
  localparam logic [11:0] OFS_DISPATCH = 12'h034;
  localparam int SP_SAVE_COUNT = 5;

  // Status word fields
  localparam int SW_IPL_LO = 16;
  localparam int SW_IPL_HI = 20;
  localparam int SW_MODE_LO = 24;
  localparam int SW_ON_INT_STACK = 26;
  localparam int SW_FPD = 27;
  localparam logic [31:0] SW_RESET = 32'h041f_0000;

  // Priority levels
  localparam logic [4:0] LVL_HALT = 5'h1f;
  localparam logic [4:0] LVL_HARD_ERR = 5'h1d;
  localparam logic [4:0] LVL_PERF = 5'h1b;
  localparam logic [4:0] LVL_SOFT_ERR = 5'h1a;
  localparam logic [4:0] LVL_IRQ0 = 5'h14;
  localparam logic [4:0] LVL_TIMER = 5'h16;
  localparam logic [4:0] LVL_NONE = 5'h00;

  // Vector offsets in the table
  localparam logic [15:0] VEC_MCHECK = 16'h0004;
  localparam logic [15:0] VEC_ACCV = 16'h0020;
  localparam logic [15:0] VEC_TNV = 16'h0024;
  localparam logic [15:0] VEC_ARITH = 16'h0034;
  localparam logic [15:0] VEC_MODIFY = 16'h003c;
  localparam logic [15:0] VEC_SOFT_ERR = 16'h0054;
  localparam logic [15:0] VEC_HARD_ERR = 16'h0060;
  localparam logic [15:0] VEC_SOFT_BASE = 16'h0080;
  localparam logic [15:0] VEC_TIMER = 16'h00c0;
  localparam logic [15:0] VEC_EMU_START = 16'h00c8;
  localparam logic [15:0] VEC_EMU_CONT = 16'h00cc;
  localparam logic [15:0] VEC_IRQ0 = 16'h00d0;

  // Vector entry stack codes
  localparam logic [1:0] STK_KERNEL = 2'b00;
  localparam logic [1:0] STK_INTERRUPT = 2'b01;

  // Arithmetic type codes that are faults; all others are traps
  localparam logic [3:0] AR_FLT_OVF = 4'h8;
  localparam logic [3:0] AR_FLT_DVZ = 4'h9;
  localparam logic [3:0] AR_FLT_UNF = 4'ha;

  // Halt codes stored with the saved status word
  localparam logic [5:0] HALT_EXTERNAL = 6'h01;
  localparam logic [5:0] HALT_STATE_BAD = 6'h02;
  localparam logic [5:0] HALT_KERNEL = 6'h03;
  localparam logic [5:0] HALT_SYS_RESTART = 6'h04;
  localparam logic [5:0] HALT_VEC_CODE = 6'h05;

  localparam int FRAME_MAX = 12;
  localparam int EMU_FRAME_LEN = 12;

  typedef enum logic [2:0] {
    EXC_ARITH = 3'b000,
    EXC_ACCV = 3'b001,
    EXC_TNV = 3'b010,
    EXC_MODIFY = 3'b011,
    EXC_EMULATE = 3'b100,
    EXC_MCHECK = 3'b101
  } ced_exc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_PUSH = 3'b010,
    ST_BRANCH = 3'b011,
    ST_RESTART = 3'b100
  } ced_state_t;
endpackage

// ### src/ced_int_arbiter.sv
// Picks the highest pending interrupt level and its vector offset.
// Assumes request inputs are already latched where they must be sticky.
`timescale 1ns/1ns
module ced_int_arbiter
  import ced_pkg::*;
#(
  parameter int NUM_IRQ = 4
) (
  input wire logic haltReq,
  input wire logic hardPend,
  input wire logic perfPend,
  input wire logic softErrPend,
  input wire logic [NUM_IRQ-1:0] irqLines,
  input wire logic timerReq,
  input wire logic [15:1] softPend,
  output logic [4:0] bestLevel,
  output logic [15:0] bestVec
);
  import ced_pkg::*;

  initial begin
    if (NUM_IRQ != 4) $error("ced_int_arbiter serves exactly four request lines");
  end

  always_comb begin
    bestLevel = LVL_NONE;
    bestVec = 16'h0000;
    for (int i = 1; i < 16; i++) begin
      if (softPend[i]) begin
        bestLevel = 5'(i); // see RULE_10
        bestVec = 16'(VEC_SOFT_BASE + 16'(4 * i));
      end
    end
    if (irqLines[0]) begin
      bestLevel = LVL_IRQ0; // see RULE_09
      bestVec = VEC_IRQ0;
    end
    if (irqLines[1]) begin
      bestLevel = 5'(LVL_IRQ0 + 5'h01);
      bestVec = 16'(VEC_IRQ0 + 16'h0004);
    end
    if (timerReq) begin
      bestLevel = LVL_TIMER;
      bestVec = VEC_TIMER;
    end
    if (irqLines[2]) begin
      bestLevel = 5'(LVL_IRQ0 + 5'h02); // see RULE_09
      bestVec = 16'(VEC_IRQ0 + 16'h0008);
    end
    if (irqLines[3]) begin
      bestLevel = 5'(LVL_IRQ0 + 5'h03);
      bestVec = 16'(VEC_IRQ0 + 16'h000c);
    end
    if (softErrPend) begin
      bestLevel = LVL_SOFT_ERR; // see RULE_08
      bestVec = VEC_SOFT_ERR;
    end
    if (perfPend) begin
      bestLevel = LVL_PERF; // see RULE_07
      bestVec = 16'h0000;
    end
    if (hardPend) begin
      bestLevel = LVL_HARD_ERR; // see RULE_06
      bestVec = VEC_HARD_ERR;
    end
    if (haltReq) begin
      bestLevel = LVL_HALT; // see RULE_05
      bestVec = 16'h0000;
    end
  end
endmodule // ced_int_arbiter

// ### src/ced_vec_entry.sv
// Splits a fetched vector entry into handler address and stack choice.
// Assumes the entry is stable while the top module samples the outputs.
`timescale 1ns/1ns
module ced_vec_entry
  import ced_pkg::*;
(
  input wire logic [31:0] entry,
  input wire logic onIntStack,
  input wire logic isException,
  output logic [31:0] handlerPc,
  output logic useIntStack,
  output logic raiseToTop,
  output logic consoleErr
);
  import ced_pkg::*;

  always_comb begin
    handlerPc = {entry[31:2], 2'b00}; // see RULE_21
    consoleErr = entry[1]; // see RULE_22
    useIntStack = 1'b0;
    raiseToTop = 1'b0;
    if (entry[1:0] == STK_KERNEL) begin
      useIntStack = onIntStack; // see RULE_22
    end else if (entry[1:0] == STK_INTERRUPT) begin
      useIntStack = 1'b1;
      raiseToTop = isException; // see RULE_22
    end
  end
endmodule // ced_vec_entry

// ### bench/ced_dispatch_properties.sv
// Dispatch port checker.
// Assumes binding onto ced_dispatch by port name.
`timescale 1ns/1ns
module ced_dispatch_chk
  import ced_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy,
  input wire logic vecRd,
  input wire logic vecAck,
  input wire logic pushValid,
  input wire logic branchValid,
  input wire logic [31:0] branchPc,
  input wire logic consoleJump,
  input wire logic [31:0] statusWord
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late");
  property p_err; pready && paddr > OFS_DISPATCH |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ipl;
    pready && pwrite && !pslverr && paddr == OFS_PRIORITY && !busy
      |=> statusWord[20:16] == $past(pwdata[4:0]);
  endproperty
  a_ipl: assert property (p_ipl) else $error("level");
  property p_align; branchValid |-> branchPc[1:0] == 2'b00; endproperty
  a_align: assert property (p_align) else $error("unaligned");
  property p_done; branchValid |=> !branchValid && !busy; endproperty
  a_done: assert property (p_done) else $error("not final");
  property p_fetch; vecRd && !vecAck |=> vecRd; endproperty
  a_fetch: assert property (p_fetch) else $error("dropped");
  property p_push; pushValid |-> ##[1:12] (branchValid || consoleJump); endproperty
  a_push: assert property (p_push) else $error("too long");
  property p_cons; consoleJump |-> ##[0:1] statusWord == SW_RESET; endproperty
  a_cons: assert property (p_cons) else $error("no init");
endmodule // ced_dispatch_chk
bind ced_dispatch ced_dispatch_chk u_ced_dispatch_chk (.*);

// ### bench/ced_vec_model.sv
// Vector table model: answers a read after lat cycles.
// Assumes vecRd holds until vecAck; handler 4000_0000 + offset.
`timescale 1ns/1ns
module ced_vec_model (
  input wire logic sys_clk,
  input wire logic vecRd,
  input wire logic [31:0] vecAddr,
  input wire logic [1:0] code,
  input wire logic [3:0] lat,
  output logic vecAck = 1'b0,
  output logic [31:0] vecData = 32'h0
);
  logic [3:0] waitCnt = 4'h0;
  always @(posedge sys_clk) begin
    vecAck <= 1'b0;
    // Inverted between answers to expose late samples
    vecData <= ~vecData;
    waitCnt <= (vecRd && !vecAck) ? waitCnt + 4'h1 : 4'h0;
    if (vecRd && !vecAck && waitCnt >= lat) begin
      vecAck <= 1'b1;
      vecData <= {16'h4000, vecAddr[15:2], code};
      waitCnt <= 4'h0;
    end
  end
endmodule // ced_vec_model

// ### bench/tb.sv
// Bench: APB tasks, interrupt and exception tables.
// Assumes the model answers every vector read.
`timescale 1ns/1ns
module tb;
  import ced_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, instrDone = 0;
  logic excReq = 0, con, err, pready, pslverr, busy, vecRd, vecAck, pushValid;
  logic pushOnIntStack, branchValid, perfService, consoleJump;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, pushData, branchPc, consoleAddr, statusWord, vecAddr;
  logic [31:0] vecData, rd, top, curPc = 32'h1000, nextPc = 32'h1004, excParam = 0;
  logic [31:0] pw[16];
  logic [8:0] src = 0;
  logic [7:0] emuOpcode = 8'h38;
  logic [3:0] excArithCode = 0, lat = 4'h1;
  logic [1:0] code = 2'b01;
  ced_exc_t excKind = EXC_ARITH;
  int np = 0, nPerf = 0, nMismatch = 0, cmpCount = 0;
  wire [3:0] irqLines = src[3:0];
  wire timerReq = src[4], hardErrIn = src[5], haltReq = src[6], softErrEvt = src[7];
  wire perfEvt = src[8], hardErrEvt = 0, interruptPoint = 0, stateBad = 0;
  wire kernelHalt = 0, sysRestart = 0;
  wire [31:0] excVaddr = ~excParam, curSp = nextPc, mcState = excParam;
  wire [7:0] mcErrType = emuOpcode;
  wire [255:0] emuSpecs = {8{excParam}};
  logic [21:0] it[8] = '{{9'h08, 5'h17, 8'hdc}, {9'h04, 5'h16, 8'hd8}, {9'h14, 5'h16, 8'hd8},
    {9'h02, 5'h15, 8'hd4}, {9'h01, 5'h14, 8'hd0}, {9'h10, 5'h16, 8'hc0},
    {9'h20, 5'h1d, 8'h60}, {9'h80, 5'h1a, 8'h54}};
  logic [19:0] et[10] = '{{EXC_ARITH, 4'h1, 8'h34, 4'd3, 1'b0},
    {EXC_ARITH, 4'h2, 8'h34, 4'd3, 1'b0}, {EXC_ARITH, 4'h7, 8'h34, 4'd3, 1'b0},
    {EXC_ARITH, 4'h8, 8'h34, 4'd3, 1'b1}, {EXC_ARITH, 4'h9, 8'h34, 4'd3, 1'b1},
    {EXC_ARITH, 4'ha, 8'h34, 4'd3, 1'b1}, {EXC_ACCV, 4'h0, 8'h20, 4'd4, 1'b1},
    {EXC_TNV, 4'h0, 8'h24, 4'd4, 1'b1}, {EXC_MODIFY, 4'h0, 8'h3c, 4'd4, 1'b1},
    {EXC_EMULATE, 4'h0, 8'hc8, 4'd12, 1'b0}};
  ced_dispatch u_ced_dispatch (.*);
  ced_vec_model u_ced_vec_model (.*);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (pushValid) begin
      pw[np] <= pushData;
      np <= np + 1;
    end
    if (perfService) nPerf <= nPerf + 1;
  end
  task automatic chk(logic [31:0] g, e);
    cmpCount++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic waitEv;
    int t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (!(branchValid | consoleJump) && t < 300);
    con = consoleJump;
  endtask
  // Pulsed sources drop after one cycle
  task automatic take(input logic [8:0] s);
    @(posedge sys_clk);
    src <= s;
    np <= 0;
    @(posedge sys_clk);
    src <= s & 9'h05f;
    @(posedge sys_clk);
    instrDone <= 1;
    @(posedge sys_clk);
    instrDone <= 0;
    waitEv;
  endtask
  task automatic frame(logic [7:0] v, int n, logic [31:0] pc, tp);
    chk({branchValid, pushOnIntStack}, 3);
    chk({24'h400000, v}, branchPc);
    chk(np, n);
    chk(pw[1], pc);
    chk(pw[n-1], tp);
  endtask
  task automatic printVerdict;
    $display("compares %0d fails %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    nMismatch++;
    printVerdict;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, OFS_STATUS, 0);
    chk(rd, SW_RESET);
    apb(0, 12'h100, 0);
    chk(err, 1);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      apb(1, OFS_PRIORITY, 0);
      nextPc <= 32'h2000 + i * 4;
      take(it[i][21:13]);
      frame(it[i][7:0], 2, nextPc, nextPc);
      chk(statusWord[20:16], it[i][12:8]);
      src <= 0;
    end
    apb(1, OFS_PRIORITY, 32'h16);
    take(9'h105);
    chk(branchValid, 0);
    chk(nPerf, 1);
    chk(statusWord[20:16], 5'h16);
    src <= 0;
    $display("interrupts done");
    for (int i = 0; i < 10; i++) begin
      apb(1, OFS_PRIORITY, 0);
      excKind <= ced_exc_t'(et[i][19:17]);
      excArithCode <= et[i][16:13];
      excParam <= 32'h5a00 + i;
      lat <= 4'(1 + i % 3);
      excReq <= 1;
      np <= 0;
      do @(posedge sys_clk); while (busy !== 1'b1);
      excReq <= 0;
      top = excKind == EXC_ARITH ? excArithCode : excKind == EXC_EMULATE ? emuOpcode : excParam;
      waitEv;
      frame(et[i][12:5], et[i][4:1], et[i][0] ? curPc : nextPc, top);
      chk(statusWord[20:16], 5'h1f);
    end
    $display("exceptions done");
    apb(1, OFS_CONSOLE, 32'h2000);
    take(9'h040);
    chk(con, 1);
    chk(consoleAddr, 32'h2000);
    src <= 0;
    apb(1, OFS_PRIORITY, 0);
    code <= 2'b10;
    take(9'h002);
    chk(con, 1);
    src <= 0;
    $display("console done");
    printVerdict;
  end
endmodule // tb
